// ---- logic/adcsr_pkg.sv ----
package adcsr_pkg;
  localparam int RESULT_W      = 24;
  localparam int MOD_W         = 16;
  localparam int ACC_W         = 40;
  localparam int FIFO_DEPTH    = 16;
  localparam int SYNC_W        = 5;
  // Sync vector positions
  localparam int SY_CONV_CLK   = 0;
  localparam int SY_SHIFT_CLK  = 1;
  localparam int SY_CHANNEL    = 2;
  localparam int SY_BUFFER     = 3;
  localparam int SY_TEMP       = 4;
  // Conversion clock figures
  localparam int CONV_CLK_HZ   = 2000000;
  localparam int MOD_RATE_HZ   = 62500;
  localparam int DATA_RATE_SPS = 120;
  localparam int MOD_DIV       = CONV_CLK_HZ / MOD_RATE_HZ;
  localparam int CONV_PER_RESULT = (CONV_CLK_HZ + DATA_RATE_SPS - 1) / DATA_RATE_SPS;
  localparam int UPDATE_LEAD   = 32;
  localparam int SETTLE_RESULTS = 3;
  localparam int BIT_CNT_W     = 5;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT_IDX  = 5'h17;
  localparam logic [BIT_CNT_W-1:0] FORCE_HIGH_IDX = 5'h18;
  localparam logic [RESULT_W-1:0] CODE_POS_FULL = 24'h7fffff;
  localparam logic [RESULT_W-1:0] CODE_NEG_FULL = 24'h800000;
  localparam logic signed [ACC_W-1:0] ACC_MAX = 40'sh00007fffff;
  localparam logic signed [ACC_W-1:0] ACC_MIN = 40'shffff800000;
  localparam logic [ACC_W-1:0] ACC_RESET = 40'h0000000000;
  localparam logic [RESULT_W-1:0] SHIFT_RESET = 24'h000000;

  typedef enum logic [1:0] {
    ADCSR_UPDATE = 2'b00,
    ADCSR_READY  = 2'b01,
    ADCSR_SHIFT  = 2'b10,
    ADCSR_DONE   = 2'b11
  } adcsr_state_type;
endpackage

// ---- logic/adcsr_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module adcsr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic         clk_en_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else if (clk_en_in) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

module adcsr_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic         clk_en_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic      [W-1:0] out_data_out
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(D);
  localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic          push;
  logic          pop;

  assign in_ready_out  = (count_reg != FULL_CNT);
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_ready_in && out_valid_out;

  always_ff @(posedge clk_in) begin
    if (clk_en_in && push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (clk_en_in) begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

module adcsr_top #(
  parameter int CONV_PER_RESULT_P = adcsr_pkg::CONV_PER_RESULT
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        srst_in,
  input  wire logic                        clk_en_in,
  input  wire logic                        conv_clk_in,
  input  wire logic                        shift_clk_in,
  input  wire logic                        channel_select_in,
  input  wire logic                        input_buffer_select_in,
  input  wire logic                        temp_diode_select_in,
  input  wire logic                        standby_in,
  input  wire logic                        gain_cal_in,
  input  wire logic                        mod_valid_in,
  output logic                             mod_ready_out,
  input  wire logic signed [adcsr_pkg::MOD_W-1:0] mod_data_in,
  output logic                             ready_and_serial_out,
  output logic                             pair1_switch_out,
  output logic                             pair2_switch_out,
  output logic                             temp_diode_switch_out,
  output logic                             buffer_enable_out,
  output logic                             reference_positive_to_pos_out,
  output logic                             reference_negative_to_neg_out
);
  import adcsr_pkg::*;

  localparam int CNT_W = $clog2(CONV_PER_RESULT_P + 1);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_PER_RESULT_P - 1);
  localparam logic [CNT_W-1:0] UPD_AT    = CNT_W'(CONV_PER_RESULT_P - UPDATE_LEAD - 1);
  localparam logic [5:0]       DIV_LAST  = 6'(MOD_DIV - 1);
  localparam logic [1:0]       SETTLE_N  = 2'(SETTLE_RESULTS);

  logic [SYNC_W-1:0]       pins_sync;
  logic                    conv_q_reg;
  logic                    shift_q_reg;
  logic [2:0]              sel_q_reg;
  logic                    conv_tick;
  logic                    shift_rise;
  logic                    toggle;
  logic [5:0]              div_reg;
  logic                    mod_tick;
  logic [CNT_W-1:0]        conv_cnt_reg;
  logic                    upd_start;
  logic                    conv_done;
  logic [1:0]              settle_reg;
  logic                    capture;
  logic signed [ACC_W-1:0] acc_reg;
  logic signed [ACC_W-1:0] acc_next;
  logic [RESULT_W-1:0]     sat_code;
  logic [RESULT_W-1:0]     shift_reg;
  logic [BIT_CNT_W-1:0]    bit_cnt_reg;
  adcsr_state_type         state_reg;
  logic                    fifo_valid;
  logic                    fifo_pop;
  logic [MOD_W-1:0]        fifo_data;
  logic                    running;

  adcsr_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk_in    (ref_clk_in),
    .srst_in   (srst_in),
    .clk_en_in (clk_en_in),
    .async_in  ({temp_diode_select_in, input_buffer_select_in, channel_select_in,
                 shift_clk_in, conv_clk_in}),
    .sync_out  (pins_sync)
  );

  // Samples queue here; the filter drains only on modulator ticks
  adcsr_fifo #(
    .W (MOD_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (ref_clk_in),
    .srst_in       (srst_in),
    .clk_en_in     (clk_en_in),
    .in_valid_in   (mod_valid_in),
    .in_ready_out  (mod_ready_out),
    .in_data_in    (mod_data_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  assign running    = !standby_in;
  assign conv_tick  = pins_sync[SY_CONV_CLK] && !conv_q_reg && running;
  assign shift_rise = pins_sync[SY_SHIFT_CLK] && !shift_q_reg;
  assign toggle     = (pins_sync[SY_TEMP:SY_CHANNEL] != sel_q_reg);
  assign mod_tick   = conv_tick && (div_reg == DIV_LAST);
  assign fifo_pop   = mod_tick && !toggle;
  assign upd_start  = conv_tick && (conv_cnt_reg == UPD_AT) && !toggle;
  assign conv_done  = conv_tick && (conv_cnt_reg == CONV_LAST) && !toggle;
  assign capture    = conv_done && (settle_reg == '0);

  always_comb begin
    acc_next = acc_reg;
    if (fifo_pop && fifo_valid) begin
      acc_next = acc_reg + ACC_W'($signed(fifo_data));
    end
  end

  // Two's complement result, clipped at full scale
  always_comb begin
    if (acc_next > ACC_MAX) begin
      sat_code = CODE_POS_FULL;
    end else if (acc_next < ACC_MIN) begin
      sat_code = CODE_NEG_FULL;
    end else begin
      sat_code = acc_next[RESULT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      conv_q_reg  <= 1'b0;
      shift_q_reg <= 1'b0;
      sel_q_reg   <= 3'h0;
    end else if (clk_en_in) begin
      conv_q_reg  <= pins_sync[SY_CONV_CLK];
      shift_q_reg <= pins_sync[SY_SHIFT_CLK];
      sel_q_reg   <= pins_sync[SY_TEMP:SY_CHANNEL];
    end
  end

  // Conversion timing; a select toggle restarts the whole filter
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      div_reg      <= '0;
      conv_cnt_reg <= '0;
      acc_reg      <= ACC_RESET;
      settle_reg   <= SETTLE_N;
    end else if (clk_en_in) begin
      if (toggle) begin
        div_reg      <= '0;
        conv_cnt_reg <= '0;
        acc_reg      <= ACC_RESET;
        settle_reg   <= SETTLE_N;
      end else if (conv_tick) begin
        div_reg      <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
        conv_cnt_reg <= (conv_cnt_reg == CONV_LAST) ? '0 : conv_cnt_reg + 1'b1;
        acc_reg      <= conv_done ? ACC_RESET : acc_next;
        if (conv_done && settle_reg != '0) begin
          settle_reg <= settle_reg - 1'b1;
        end
      end
    end
  end

  // Serial readout; shift clocks during an update are ignored
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_reg            <= ADCSR_UPDATE;
      shift_reg            <= SHIFT_RESET;
      bit_cnt_reg          <= '0;
      ready_and_serial_out <= 1'b1;
    end else if (clk_en_in) begin
      if (toggle || (conv_done && !capture)) begin
        state_reg            <= ADCSR_UPDATE;
        ready_and_serial_out <= 1'b1;
      end else if (capture) begin
        shift_reg            <= sat_code;
        bit_cnt_reg          <= '0;
        state_reg            <= ADCSR_READY;
        ready_and_serial_out <= 1'b0;
      end else if (upd_start) begin
        state_reg            <= ADCSR_UPDATE;
        ready_and_serial_out <= 1'b1;
      end else if (shift_rise) begin
        unique case (state_reg)
          ADCSR_READY, ADCSR_SHIFT: begin
            if (bit_cnt_reg == FORCE_HIGH_IDX) begin
              ready_and_serial_out <= 1'b1;
              state_reg            <= ADCSR_DONE;
            end else begin
              ready_and_serial_out <= shift_reg[RESULT_W-1];
              shift_reg            <= {shift_reg[RESULT_W-2:0], 1'b0};
              bit_cnt_reg          <= bit_cnt_reg + 1'b1;
              state_reg            <= ADCSR_SHIFT;
            end
          end
          ADCSR_UPDATE, ADCSR_DONE: begin
            state_reg <= state_reg;
          end
        endcase
      end
    end
  end

  // Input switch routing; calibration overrides the channel and temp-diode selects
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pair1_switch_out              <= 1'b0;
      pair2_switch_out              <= 1'b0;
      temp_diode_switch_out         <= 1'b0;
      buffer_enable_out             <= 1'b0;
      reference_positive_to_pos_out <= 1'b0;
      reference_negative_to_neg_out <= 1'b0;
    end else if (clk_en_in) begin
      pair1_switch_out      <= !gain_cal_in && !sel_q_reg[2] && !sel_q_reg[0];
      pair2_switch_out      <= !gain_cal_in && !sel_q_reg[2] && sel_q_reg[0];
      temp_diode_switch_out <= !gain_cal_in && sel_q_reg[2];
      buffer_enable_out     <= sel_q_reg[1];
      reference_positive_to_pos_out <= gain_cal_in;
      reference_negative_to_neg_out <= gain_cal_in;
    end
  end

  a_ready_on_capture: assert property (@(posedge ref_clk_in) disable iff (srst_in || !clk_en_in)
    capture |=> !ready_and_serial_out && state_reg == ADCSR_READY)
    else $error("Ready not signalled after capture");

  a_msb_first_out: assert property (@(posedge ref_clk_in) disable iff (srst_in || !clk_en_in)
    (state_reg == ADCSR_READY && shift_rise && !toggle && !conv_done && !upd_start)
    |=> ready_and_serial_out == $past(shift_reg[RESULT_W-1]))
    else $error("First shift edge did not present the MSB");

  a_bit_advance: assert property (@(posedge ref_clk_in) disable iff (srst_in || !clk_en_in)
    (state_reg == ADCSR_SHIFT && shift_rise && bit_cnt_reg <= LAST_BIT_IDX && !toggle
     && !conv_done && !upd_start) |=> bit_cnt_reg == $past(bit_cnt_reg) + 5'h01)
    else $error("Shift edge did not advance one bit");

  a_forced_high: assert property (@(posedge ref_clk_in) disable iff (srst_in || !clk_en_in)
    (state_reg == ADCSR_SHIFT && bit_cnt_reg == FORCE_HIGH_IDX && shift_rise && !toggle
     && !conv_done) |=> ready_and_serial_out ##1 state_reg != ADCSR_SHIFT)
    else $error("Extra edge did not force the line high");

  a_hold_last: assert property (@(posedge ref_clk_in) disable iff (srst_in || !clk_en_in)
    (state_reg == ADCSR_SHIFT && !shift_rise && !toggle && !conv_done && !upd_start)
    |=> $stable(ready_and_serial_out))
    else $error("Line moved without a shift edge");

  a_update_high: assert property (@(posedge ref_clk_in) disable iff (srst_in || !clk_en_in)
    upd_start |=> ready_and_serial_out && state_reg == ADCSR_UPDATE)
    else $error("Update did not drive the line high");

  a_settle_hide: assert property (@(posedge ref_clk_in) disable iff (srst_in || !clk_en_in)
    toggle |=> ready_and_serial_out && settle_reg == SETTLE_N && conv_cnt_reg == '0)
    else $error("Select toggle did not restart and hide data");

  a_clip_code: assert property (@(posedge ref_clk_in) disable iff (srst_in || !clk_en_in)
    capture && acc_next > ACC_MAX |=> shift_reg == CODE_POS_FULL)
    else $error("Positive overrange not clipped");

  a_mod_tick_rate: assert property (@(posedge ref_clk_in) disable iff (srst_in || !clk_en_in)
    mod_tick && !toggle |=> div_reg == '0 && !fifo_pop)
    else $error("Modulator sampled off its divider");

  a_standby_freeze: assert property (@(posedge ref_clk_in) disable iff (srst_in || !clk_en_in)
    standby_in && !toggle |=> $stable(conv_cnt_reg))
    else $error("Conversion advanced in standby");

  a_cal_routing: assert property (@(posedge ref_clk_in) disable iff (srst_in || !clk_en_in)
    gain_cal_in |=> reference_positive_to_pos_out && !pair1_switch_out && !pair2_switch_out
    && !temp_diode_switch_out)
    else $error("Calibration did not open input switches");

  a_pair_select: assert property (@(posedge ref_clk_in) disable iff (srst_in || !clk_en_in)
    !gain_cal_in && !sel_q_reg[2] |=> pair2_switch_out == $past(sel_q_reg[0])
    && pair1_switch_out == !$past(sel_q_reg[0]))
    else $error("Channel select routed the wrong pair");
endmodule

`default_nettype wire

// ---- test/adcsr_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module adcsr_host_model (
  input  wire logic                            line_in,
  input  wire logic [adcsr_pkg::BIT_CNT_W-1:0] n_edges_in,
  output logic                                 shift_clk_out,
  output logic      [adcsr_pkg::RESULT_W-1:0]  word_out,
  output logic                                 word_valid_out,
  output logic                                 post_level_out
);
  import adcsr_pkg::*;
  int k;
  initial begin
    shift_clk_out = 1'b0;
    word_out = '0;
    word_valid_out = 1'b0;
    post_level_out = 1'b0;
    forever begin
      wait (line_in === 1'b0);
      // Let a select toggle win before the first edge
      #200;
      if (line_in === 1'b0) begin
        for (k = 1; k <= int'(n_edges_in); k++) begin
          shift_clk_out = 1'b1;
          #80;
          if (k <= RESULT_W) word_out[RESULT_W-k] = line_in;
          shift_clk_out = 1'b0;
          #80;
        end
        post_level_out = line_in;
        word_valid_out = 1'b1;
        #20;
        word_valid_out = 1'b0;
        // Read ends well before the update window
        wait (line_in === 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import adcsr_pkg::*;
  localparam int P = 128;
  localparam int PER_RES = P / MOD_DIV;
  typedef struct packed {
    logic [RESULT_W-1:0] word;
    logic                level;
  } adcsr_exp_type;
  logic ref_clk, srst, conv_clk, shift_clk, sel_ch, sel_buf, sel_temp, standby, gain_cal;
  logic mod_valid, mod_ready, line, pair1, pair2, temp_sw, buf_en, ref_p, ref_n;
  logic signed [MOD_W-1:0] sample_v, mod_data;
  logic [RESULT_W-1:0] word;
  logic word_valid, post_level, feed, hs_go;
  logic [BIT_CNT_W-1:0] n_edges;
  adcsr_exp_type exp_q[$];
  adcsr_exp_type e;
  int fails, n_tests, pushes, n_reads, i, k;
  // Set before any process runs; a zero half period would spin at time 0
  real conv_half = 40.0;

  adcsr_top #(.CONV_PER_RESULT_P(P)) u_dut (
    .ref_clk_in(ref_clk), .srst_in(srst), .clk_en_in(1'b1), .conv_clk_in(conv_clk),
    .shift_clk_in(shift_clk), .channel_select_in(sel_ch), .input_buffer_select_in(sel_buf),
    .temp_diode_select_in(sel_temp), .standby_in(standby), .gain_cal_in(gain_cal),
    .mod_valid_in(mod_valid), .mod_ready_out(mod_ready), .mod_data_in(mod_data),
    .ready_and_serial_out(line), .pair1_switch_out(pair1), .pair2_switch_out(pair2),
    .temp_diode_switch_out(temp_sw), .buffer_enable_out(buf_en),
    .reference_positive_to_pos_out(ref_p), .reference_negative_to_neg_out(ref_n));

  adcsr_host_model u_host (
    .line_in(line), .n_edges_in(n_edges), .shift_clk_out(shift_clk),
    .word_out(word), .word_valid_out(word_valid), .post_level_out(post_level));

  always #2.5 ref_clk = ~ref_clk;
  always #(conv_half) conv_clk = ~conv_clk;

  // Valid only changes once the previous sample was taken
  always @(posedge ref_clk) begin
    if (mod_valid && mod_ready) pushes++;
    if (!mod_valid || mod_ready) begin
      hs_go = feed && ($urandom_range(0, 3) != 0);
      #1;
      mod_valid = hs_go;
      mod_data = sample_v;
    end
  end

  task automatic check_word(input string what, input logic [RESULT_W-1:0] exp,
                            input logic [RESULT_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_flags(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  always @(posedge word_valid) begin
    n_reads++;
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check_word("result word", e.word, word);
      check_flags("line after read", {7'h00, e.level}, {7'h00, post_level});
    end
  end

  task automatic wait_reads(input int n);
    repeat (n) @(posedge word_valid);
    // Let the checker take this word before a new note is queued
    #1;
  endtask

  task automatic run_value(input int v, input logic fd, input logic tog, input int edges);
    logic [RESULT_W-1:0] w;
    sample_v = MOD_W'(v);
    feed = fd;
    w = fd ? RESULT_W'(v * PER_RES) : 24'h000000;
    if (tog) begin
      @(negedge line);
      @(posedge ref_clk);
      #1 sel_ch = ~sel_ch;
      repeat (6) @(posedge ref_clk);
      check_flags("line after toggle", 8'h01, {7'h00, line});
    end
    // Older samples still sit in the FIFO
    wait_reads(tog ? 2 : 6);
    n_edges = BIT_CNT_W'(edges);
    exp_q.push_back('{w, (edges == 25) ? 1'b1 : w[0]});
    wait_reads(1);
    n_edges = 5'h19;
  endtask

  task automatic check_rate(input real half);
    realtime t0;
    real d;
    conv_half = half;
    wait_reads(2);
    t0 = $realtime;
    wait_reads(1);
    d = $realtime - t0 - P * 2.0 * half;
    check_flags("result interval ok", 8'h01, {7'h00, d < 12.0 && d > -12.0});
  endtask

  task automatic wrap_up();
    $display("Checks run %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #480000;
    fails++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    wrap_up();
  end

  initial begin
    void'($urandom(98347));
    ref_clk = 0; conv_clk = 0; conv_half = 40.0; srst = 1; sel_ch = 0; sel_buf = 0;
    sel_temp = 0; standby = 0; gain_cal = 0; mod_valid = 0; mod_data = '0; sample_v = '0;
    feed = 0; n_edges = 5'h19;
    repeat (20) @(posedge ref_clk);
    #1 srst = 0;
    feed = 1;
    for (i = 0; i < 200 && mod_ready !== 1'b0; i++) begin
      @(posedge ref_clk);
      #2;
    end
    check_flags("pushes until full", 8'(FIFO_DEPTH), 8'(pushes));
    run_value(int'($urandom_range(1, 32767)), 1'b1, 1'b1, 25);
    run_value(-int'($urandom_range(1, 32768)), 1'b1, 1'b0, 24);
    run_value(0, 1'b0, 1'b1, 24);
    feed = 1;
    check_rate(60.0);
    check_rate(40.0);
    @(posedge ref_clk);
    #1 standby = 1;
    k = n_reads;
    #(3 * P * 80);
    check_flags("reads in standby", 8'(k), 8'(n_reads));
    check_flags("line in standby", 8'h01, {7'h00, line});
    @(posedge ref_clk);
    #1 standby = 0;
    wait_reads(1);
    for (i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      #1 {gain_cal, sel_temp, sel_buf, sel_ch} = 4'(i);
      repeat (8) @(posedge ref_clk);
      #1;
      check_flags("switch levels",
        {2'b00, sel_buf, gain_cal, gain_cal, !gain_cal && sel_temp,
         !gain_cal && !sel_temp && sel_ch, !gain_cal && !sel_temp && !sel_ch},
        {2'b00, buf_en, ref_p, ref_n, temp_sw, pair2, pair1});
    end
    wrap_up();
  end
endmodule
`default_nettype wire
